// ---- asw_consts.svh ----
/*
  Constants for the converter sequencer with window detector: register
  addresses, field codes, reset values and timing figures.
  Assumes a 50 MHz system clock and an 8-bit special-function register bus.
*/
// Overview of operation
// RULE1: start source field picks software busy write, timer 1, external rising edge, timer 2.
// RULE2: burst off: converter power simply follows the converter enable bit.
// RULE3: burst on with enable set: converter stays powered, no very low power state.
// RULE4: burst on with enable clear: low power, power up after every start event.
// RULE5: burst power-up delay is (field bits 7:4 plus one) times 200 ns.
// RULE6: tracking mode 01 post, 10 pre, 11 dual; 00 reserved, never written.
// RULE7: post-track lasts 2, 4, 8 or 16 SAR periods plus two system clocks.
// RULE8: window detector compares each result against greater and less limits.
// RULE9: limit ordering decides whether the flag means inside or outside window.
// RULE10: window match flag is software readable and usable as interrupt request.
// RULE11: enable clear keeps converter in shutdown; set makes it ready to convert.
// RULE12: conversion-done flag sets on completion and holds until software clears it.
// RULE13: less limit above greater limit: hit needs greater < result < less, strictly.
// RULE14: window match flag holds until software writes zero; hardware never clears it.
// RULE15: justify bit zero places result right-justified, one left-justified.
`ifndef ASW_CONSTS_SVH
`define ASW_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ASW_ADDR_CONTROL 8'hE8
`define ASW_ADDR_TRACK 8'hBA
`define ASW_ADDR_GREATER_HIGH 8'hC4
`define ASW_ADDR_GREATER_LOW 8'hC3
`define ASW_ADDR_LESS_HIGH 8'hC6
`define ASW_ADDR_LESS_LOW 8'hC5
`define ASW_ADDR_RESULT_HIGH 8'hBE
`define ASW_ADDR_RESULT_LOW 8'hBD

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ASW_RESET_CONTROL 8'h00
`define ASW_RESET_TRACK 8'hFF
`define ASW_RESET_GREATER 16'hFFFF
`define ASW_RESET_LESS 16'h0000

// ----------------------------------------------------------------
// field codes
// ----------------------------------------------------------------
`define ASW_SRC_SOFTWARE 2'h0
`define ASW_SRC_TIMER1 2'h1
`define ASW_SRC_EXTERNAL 2'h2
`define ASW_SRC_TIMER2 2'h3
`define ASW_TRACK_RESERVED 2'h0
`define ASW_TRACK_POST 2'h1
`define ASW_TRACK_PRE 2'h2
`define ASW_TRACK_DUAL 2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASW_CLOCK_MHZ 50
`define ASW_POWERUP_STEP_NS 200
`define ASW_POWERUP_STEP_CYCLES ((`ASW_POWERUP_STEP_NS * `ASW_CLOCK_MHZ + 999) / 1000)
`define ASW_POST_TRACK_EXTRA_CYCLES 2
`define ASW_SAR_DIVIDE_DEFAULT 2

`endif

// ---- asw_pkg.sv ----
/*
  Types for the converter sequencer with window detector.
  Assumes asw_consts.svh holds the numeric constants.
*/
package asw_pkg;

  // ----------------------------------------------------------------
  // register layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic converterEnable;
    logic burstPowerEnable;
    logic conversionDoneFlag;
    logic conversionBusyBit;
    logic windowMatchFlag;
    logic leftJustifySelect;
    logic [1:0] startSourceSelect;
  } asw_control_type;

  typedef struct packed {
    logic [3:0] burstPowerupTime;
    logic [1:0] trackingModeSelect;
    logic [1:0] postTrackTime;
  } asw_track_type;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_POWERUP = 4'h2,
    SEQ_TRACK = 4'h4,
    SEQ_CONVERT = 4'h8
  } asw_seq_type;

  // ----------------------------------------------------------------
  // whole state of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    asw_control_type control;
    asw_track_type track;
    logic [15:0] greaterLimit;
    logic [15:0] lessLimit;
    logic [15:0] result;
    asw_seq_type seq;
    logic [15:0] count;
    logic startPulse;
    logic extPrev;
    logic [7:0] readData;
  } asw_state_type;

  // ----------------------------------------------------------------
  // bus and core carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] writeData;
    logic writeStrobe;
    logic readStrobe;
  } asw_bus_type;

  typedef struct packed {
    logic powered;
    logic tracking;
    logic startConvert;
  } asw_core_type;

endpackage : asw_pkg

// ---- asw_sequencer.sv ----
/*
  Converter sequencer: start selection, burst power-up timing, post-track
  timing, result justification and window compare, with its registers on
  the special-function register bus.
  Assumes all inputs are synchronous to clock, and that the analog core
  pulses coreDone for one clock with coreResult valid when it finishes.
*/
`timescale 1ns/1ns
`include "asw_consts.svh"

module asw_sequencer import asw_pkg::*; #(
  parameter int SAR_DIVIDE = `ASW_SAR_DIVIDE_DEFAULT
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire asw_bus_type bus,
  output logic [7:0] readData,
  input wire logic timer1Overflow,
  input wire logic timer2Overflow,
  input wire logic externalConvertStart,
  input wire logic coreDone,
  input wire logic [11:0] coreResult,
  output asw_core_type core,
  output logic conversionDoneRequest,
  output logic windowMatchRequest
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // post-track count must fit the 16-bit counter: 16 periods of SAR_DIVIDE
  if (SAR_DIVIDE < 1 || SAR_DIVIDE > 4000) begin : gen_bad_divide
    $error("SAR_DIVIDE out of range");
  end

  localparam logic [15:0] STEP_CYCLES = 16'(`ASW_POWERUP_STEP_CYCLES);
  localparam logic [15:0] SAR_CYCLES = 16'(SAR_DIVIDE);
  localparam logic [15:0] EXTRA_CYCLES = 16'(`ASW_POST_TRACK_EXTRA_CYCLES);

  asw_state_type state_reg;
  asw_state_type state_next;

  logic startEvent;
  logic softwareStart;
  logic [15:0] justified;
  logic [15:0] powerupCycles;
  logic [15:0] postTrackCycles;
  logic postTrackUsed;
  logic windowHit;

  // ----------------------------------------------------------------
  // start selection and timing figures
  // ----------------------------------------------------------------
  assign softwareStart = bus.writeStrobe && bus.addr == `ASW_ADDR_CONTROL && bus.writeData[4]
    && bus.writeData[1:0] == `ASW_SRC_SOFTWARE;

  always_comb begin
    case (state_reg.control.startSourceSelect) // RULE1
      `ASW_SRC_SOFTWARE: startEvent = softwareStart;
      `ASW_SRC_TIMER1: startEvent = timer1Overflow;
      `ASW_SRC_EXTERNAL: startEvent = externalConvertStart && !state_reg.extPrev;
      `ASW_SRC_TIMER2: startEvent = timer2Overflow;
      default: startEvent = 1'b0;
    endcase
  end

  // RULE5
  assign powerupCycles = 16'(({12'h000, state_reg.track.burstPowerupTime} + 16'h0001) * STEP_CYCLES);
  // RULE7
  assign postTrackCycles = 16'((16'h0002 << state_reg.track.postTrackTime) * SAR_CYCLES + EXTRA_CYCLES);
  // pre-tracking tracks before the start, so no interval follows it; the
  // reserved code is treated as post-tracking
  assign postTrackUsed = state_reg.track.trackingModeSelect != `ASW_TRACK_PRE; // RULE6

  // ----------------------------------------------------------------
  // justification and window compare
  // ----------------------------------------------------------------
  always_comb begin
    if (state_reg.control.leftJustifySelect) begin // RULE15
      justified = {coreResult, 4'h0};
    end else begin
      justified = {4'h0, coreResult};
    end
  end

  always_comb begin
    if (state_reg.lessLimit > state_reg.greaterLimit) begin // RULE9
      windowHit = justified > state_reg.greaterLimit && justified < state_reg.lessLimit; // RULE13
    end else begin
      windowHit = justified < state_reg.lessLimit || justified > state_reg.greaterLimit; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic conversionFinished;
    conversionFinished = 1'b0;
    state_next = state_reg;
    state_next.startPulse = 1'b0;
    state_next.extPrev = externalConvertStart;

    // register writes
    if (bus.writeStrobe) begin
      case (bus.addr)
        `ASW_ADDR_CONTROL: begin
          state_next.control.converterEnable = bus.writeData[7];
          state_next.control.burstPowerEnable = bus.writeData[6];
          state_next.control.conversionDoneFlag = bus.writeData[5]; // RULE12
          state_next.control.windowMatchFlag = bus.writeData[3]; // RULE14
          state_next.control.leftJustifySelect = bus.writeData[2];
          state_next.control.startSourceSelect = bus.writeData[1:0];
        end
        `ASW_ADDR_TRACK: state_next.track = bus.writeData;
        `ASW_ADDR_GREATER_HIGH: state_next.greaterLimit[15:8] = bus.writeData;
        `ASW_ADDR_GREATER_LOW: state_next.greaterLimit[7:0] = bus.writeData;
        `ASW_ADDR_LESS_HIGH: state_next.lessLimit[15:8] = bus.writeData;
        `ASW_ADDR_LESS_LOW: state_next.lessLimit[7:0] = bus.writeData;
        default: ;
      endcase
    end

    // sequencer; starts are ignored while shut down or already converting
    case (state_reg.seq)
      SEQ_IDLE: begin
        if (startEvent && (state_reg.control.converterEnable || state_reg.control.burstPowerEnable)) begin // RULE11
          state_next.control.conversionBusyBit = 1'b1;
          if (state_reg.control.burstPowerEnable && !state_reg.control.converterEnable) begin // RULE4
            state_next.seq = SEQ_POWERUP;
            state_next.count = powerupCycles; // RULE5
          end else if (postTrackUsed) begin
            state_next.seq = SEQ_TRACK;
            state_next.count = postTrackCycles; // RULE7
          end else begin
            state_next.seq = SEQ_CONVERT;
            state_next.startPulse = 1'b1;
          end
        end
      end
      SEQ_POWERUP: begin
        if (state_reg.count > 16'h0001) begin
          state_next.count = state_reg.count - 16'h0001;
        end else if (postTrackUsed) begin
          state_next.seq = SEQ_TRACK;
          state_next.count = postTrackCycles;
        end else begin
          state_next.seq = SEQ_CONVERT;
          state_next.startPulse = 1'b1;
        end
      end
      SEQ_TRACK: begin
        if (state_reg.count > 16'h0001) begin
          state_next.count = state_reg.count - 16'h0001;
        end else begin
          state_next.seq = SEQ_CONVERT;
          state_next.startPulse = 1'b1;
        end
      end
      SEQ_CONVERT: begin
        if (coreDone) begin
          conversionFinished = 1'b1;
          state_next.seq = SEQ_IDLE;
          state_next.control.conversionBusyBit = 1'b0;
          state_next.result = justified;
        end
      end
      default: begin
        state_next.seq = SEQ_IDLE;
        state_next.control.conversionBusyBit = 1'b0;
      end
    endcase

    // a hardware set in the same cycle as a software clear wins
    if (conversionFinished) begin
      state_next.control.conversionDoneFlag = 1'b1; // RULE12
      if (windowHit) begin
        state_next.control.windowMatchFlag = 1'b1; // RULE8
      end
    end

    // read data is captured into a flop so the bus sees a stable byte
    if (bus.readStrobe) begin
      case (bus.addr)
        `ASW_ADDR_CONTROL: state_next.readData = state_reg.control; // RULE10
        `ASW_ADDR_TRACK: state_next.readData = state_reg.track;
        `ASW_ADDR_GREATER_HIGH: state_next.readData = state_reg.greaterLimit[15:8];
        `ASW_ADDR_GREATER_LOW: state_next.readData = state_reg.greaterLimit[7:0];
        `ASW_ADDR_LESS_HIGH: state_next.readData = state_reg.lessLimit[15:8];
        `ASW_ADDR_LESS_LOW: state_next.readData = state_reg.lessLimit[7:0];
        `ASW_ADDR_RESULT_HIGH: state_next.readData = state_reg.result[15:8];
        `ASW_ADDR_RESULT_LOW: state_next.readData = state_reg.result[7:0];
        default: state_next.readData = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg.control <= `ASW_RESET_CONTROL;
      state_reg.track <= `ASW_RESET_TRACK;
      state_reg.greaterLimit <= `ASW_RESET_GREATER;
      state_reg.lessLimit <= `ASW_RESET_LESS;
      state_reg.result <= 16'h0000;
      state_reg.seq <= SEQ_IDLE;
      state_reg.count <= 16'h0000;
      state_reg.startPulse <= 1'b0;
      state_reg.extPrev <= 1'b0;
      state_reg.readData <= 8'h00;
    end else if (clockEnable) begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // all members of the core carrier come from this one process, so it has a single driver
  always_comb begin
    if (!state_reg.control.burstPowerEnable) begin
      core.powered = state_reg.control.converterEnable; // RULE2
    end else begin
      // enable set keeps it up; otherwise only while the sequencer is away from SEQ_IDLE
      core.powered = state_reg.control.converterEnable || state_reg.seq != SEQ_IDLE; // RULE3
    end
    core.tracking = state_reg.seq == SEQ_TRACK
      || (state_reg.seq == SEQ_IDLE && state_reg.track.trackingModeSelect[1] && core.powered); // RULE6
    core.startConvert = state_reg.startPulse;
  end

  assign readData = state_reg.readData;
  assign conversionDoneRequest = state_reg.control.conversionDoneFlag;
  assign windowMatchRequest = state_reg.control.windowMatchFlag; // RULE10

endmodule : asw_sequencer

// ---- asw_sequencer_asserts.sv ----
/*
  Port-level checker for asw_sequencer: flags, read capture, start pulses.
  Assumes it is bound to asw_sequencer, one clock, reset rst.
*/
`timescale 1ns/1ns
`include "asw_consts.svh"
module asw_sequencer_asserts import asw_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire asw_bus_type bus,
  input wire logic [7:0] readData,
  input wire logic timer1Overflow,
  input wire logic timer2Overflow,
  input wire logic externalConvertStart,
  input wire logic coreDone,
  input wire logic [11:0] coreResult,
  input wire asw_core_type core,
  input wire logic conversionDoneRequest,
  input wire logic windowMatchRequest
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic ctlWrite;
  assign ctlWrite = bus.writeStrobe && bus.addr == `ASW_ADDR_CONTROL;
  done_set_a: assert property (clockEnable && coreDone |=> conversionDoneRequest)
    else $error("done flag not set");
  done_hold_a: assert property (clockEnable && conversionDoneRequest && !ctlWrite |=> conversionDoneRequest)
    else $error("done flag dropped");
  window_hold_a: assert property (windowMatchRequest && !ctlWrite |=> windowMatchRequest)
    else $error("window flag dropped");
  window_cause_a: assert property ($rose(windowMatchRequest) |-> $past(coreDone) || $past(ctlWrite))
    else $error("window flag without cause");
  flag_read_a: assert property (clockEnable && bus.readStrobe && bus.addr == `ASW_ADDR_CONTROL |=>
    readData[3] == $past(windowMatchRequest) && readData[5] == $past(conversionDoneRequest))
    else $error("flag readback wrong");
  start_power_a: assert property (core.startConvert |-> core.powered)
    else $error("start while unpowered");
  start_pulse_a: assert property (clockEnable && core.startConvert |=> !core.startConvert)
    else $error("start pulse too long");
  track_power_a: assert property (core.tracking |-> core.powered)
    else $error("tracking while unpowered");
  read_hold_a: assert property (!bus.readStrobe |=> $stable(readData))
    else $error("read data moved");
endmodule : asw_sequencer_asserts

bind asw_sequencer asw_sequencer_asserts asw_sequencer_asserts_inst (.clock(clock), .rst(rst),
  .clockEnable(clockEnable), .bus(bus), .readData(readData), .timer1Overflow(timer1Overflow),
  .timer2Overflow(timer2Overflow), .externalConvertStart(externalConvertStart), .coreDone(coreDone),
  .coreResult(coreResult), .core(core), .conversionDoneRequest(conversionDoneRequest),
  .windowMatchRequest(windowMatchRequest));

// ---- asw_sequencer_tb.sv ----
/*
  Self-checking bench for asw_sequencer, SAR_DIVIDE of 1.
  Assumes the checker is bound in; the bench plays bus, timers and core.
*/
`timescale 1ns/1ns
module asw_sequencer_tb import asw_pkg::*; ();
  logic clock, rst, clockEnable, timer1Overflow, timer2Overflow, externalConvertStart, coreDone;
  logic conversionDoneRequest, windowMatchRequest;
  logic [7:0] readData;
  logic [11:0] coreResult;
  asw_bus_type bus;
  asw_core_type core;
  int fails, checks;

  asw_sequencer #(.SAR_DIVIDE(1)) asw_sequencer_inst (.clock(clock), .rst(rst), .clockEnable(clockEnable),
    .bus(bus), .readData(readData), .timer1Overflow(timer1Overflow), .timer2Overflow(timer2Overflow),
    .externalConvertStart(externalConvertStart), .coreDone(coreDone), .coreResult(coreResult),
    .core(core), .conversionDoneRequest(conversionDoneRequest), .windowMatchRequest(windowMatchRequest));

  always #10 clock = ~clock;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // strobe drops a cycle before the next access so no signal moves twice at one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus = '{a, d, 1'b1, 1'b0};
    @(negedge clock);
    bus.writeStrobe = 1'b0;
    @(negedge clock);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    bus = '{a, 8'h00, 1'b0, 1'b1};
    @(negedge clock);
    bus.readStrobe = 1'b0;
    chk({8'h00, readData}, {8'h00, exp});
    @(negedge clock);
  endtask : rdchk

  // wait for the start pulse, check its delay, then finish as the core would
  task automatic conv(input logic [11:0] r, input int exp);
    int n;
    n = 0;
    while (core.startConvert !== 1'b1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n >= 400) begin
      fails++;
      report_and_stop();
    end
    // software starts are seen one cycle earlier than pin starts, since wr returns later
    chk(16'(n >= exp - 1 && n <= exp), 16'h0001);
    coreResult = r;
    coreDone = 1'b1;
    @(negedge clock);
    coreDone = 1'b0;
    @(negedge clock);
  endtask : conv

  task automatic fire(input int s);
    if (s == 1) timer1Overflow = 1'b1;
    else if (s == 2) externalConvertStart = 1'b1;
    else timer2Overflow = 1'b1;
    @(negedge clock);
    timer1Overflow = 1'b0;
    timer2Overflow = 1'b0;
  endtask : fire

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    logic [7:0] a [8] = '{8'hE8, 8'hBA, 8'hC4, 8'hC3, 8'hC6, 8'hC5, 8'hBE, 8'h00};
    logic [7:0] e [8] = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    foreach (a[i]) rdchk(a[i], e[i]);
  endtask : test_reset

  task automatic test_track();
    // the start decode sees the enable bit as it was before the write, so enable first
    wr(8'hE8, 8'h80);
    for (int k = 0; k < 4; k++) begin
      wr(8'hBA, 8'hF4 | 8'(k));
      wr(8'hE8, 8'h90);
      conv(12'h123, (2 << k) + 2);
    end
    rdchk(8'hBE, 8'h01);
    rdchk(8'hBD, 8'h23);
    wr(8'hE8, 8'h94);
    conv(12'hABC, 18);
    rdchk(8'hBE, 8'hAB);
    rdchk(8'hBD, 8'hC0);
    rdchk(8'hE8, 8'hA4);
    chk({15'h0, conversionDoneRequest}, 16'h0001);
    chk({15'h0, core.tracking}, 16'h0000);
    wr(8'hBA, 8'hF8);
    chk({15'h0, core.tracking}, 16'h0001);
    // pre-tracking starts at once; a timer start lets conv see the one-cycle pulse
    wr(8'hE8, 8'h81);
    fire(1);
    conv(12'h000, 0);
    wr(8'hE8, 8'h80);
  endtask : test_track

  task automatic test_window();
    logic [15:0] gt [6] = '{16'h0100, 16'h0100, 16'h0100, 16'h0200, 16'h0200, 16'h0200};
    logic [15:0] lt [6] = '{16'h0200, 16'h0200, 16'h0200, 16'h0100, 16'h0100, 16'h0100};
    logic [11:0] r [6] = '{12'h150, 12'h200, 12'h100, 12'h050, 12'h150, 12'h201};
    logic h [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    wr(8'hBA, 8'hF4);
    foreach (r[i]) begin
      wr(8'hC4, gt[i][15:8]);
      wr(8'hC3, gt[i][7:0]);
      wr(8'hC6, lt[i][15:8]);
      wr(8'hC5, lt[i][7:0]);
      wr(8'hE8, 8'h90);
      conv(r[i], 4);
      chk({15'h0, windowMatchRequest}, {15'h0, h[i]});
    end
    // flag must survive a later miss
    wr(8'hE8, 8'h81);
    fire(1);
    conv(12'h050, 4);
    fire(1);
    conv(12'h150, 4);
    chk({15'h0, windowMatchRequest}, 16'h0001);
    rdchk(8'hE8, 8'hA9);
    // a frozen block must not take the write that would clear both flags
    clockEnable = 1'b0;
    wr(8'hE8, 8'h00);
    clockEnable = 1'b1;
    rdchk(8'hE8, 8'hA9);
  endtask : test_window

  task automatic test_sources();
    for (int s = 1; s < 4; s++) begin
      wr(8'hE8, 8'h80 | 8'(s));
      fire(s);
      conv(12'h000, 4);
      externalConvertStart = 1'b0;
    end
  endtask : test_sources

  task automatic test_burst();
    wr(8'hE8, 8'h00);
    chk({15'h0, core.powered}, 16'h0000);
    wr(8'hE8, 8'h80);
    chk({15'h0, core.powered}, 16'h0001);
    wr(8'hE8, 8'h40);
    chk({15'h0, core.powered}, 16'h0000);
    wr(8'hBA, 8'h35);
    wr(8'hE8, 8'h50);
    chk({15'h0, core.powered}, 16'h0001);
    conv(12'h000, 46);
    chk({15'h0, core.powered}, 16'h0000);
    wr(8'hE8, 8'hC0);
    chk({15'h0, core.powered}, 16'h0001);
    wr(8'hE8, 8'hD0);
    conv(12'h000, 6);
    chk({15'h0, core.powered}, 16'h0001);
  endtask : test_burst

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    clockEnable = 1'b1;
    bus = '0;
    {timer1Overflow, timer2Overflow, externalConvertStart, coreDone} = 4'h0;
    coreResult = 12'h000;
    fails = 0;
    checks = 0;
    repeat (12) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    test_reset();
    test_track();
    test_window();
    test_sources();
    test_burst();
    report_and_stop();
  end
endmodule : asw_sequencer_tb
